//--- rtl/frc_pkg.sv
/*
 * Package for the fault retry controller: fault codes, class masks, limits and timing.
 * Assumes a 100 MHz clock and a 0.1 s timebase derived from it inside the controller.
 */
package frc_pkg;

	// ----------------------------------------------------------------
	// Fault codes
	// ----------------------------------------------------------------
	localparam int FAULT_W = 5;
	localparam logic [4:0] FLT_NONE = 5'h00;
	localparam logic [4:0] FLT_OC1 = 5'h01;
	localparam logic [4:0] FLT_OC2 = 5'h02;
	localparam logic [4:0] FLT_OC3 = 5'h03;
	localparam logic [4:0] FLT_OV1 = 5'h04;
	localparam logic [4:0] FLT_OV2 = 5'h05;
	localparam logic [4:0] FLT_OV3 = 5'h06;
	localparam logic [4:0] FLT_MTHERM = 5'h07;
	localparam logic [4:0] FLT_DTHERM = 5'h08;
	localparam logic [4:0] FLT_BRAKE = 5'h09;
	localparam logic [4:0] FLT_GROUND = 5'h0a;
	localparam logic [4:0] FLT_COMM = 5'h0b;
	localparam logic [4:0] FLT_ETHERM = 5'h0c;
	localparam logic [4:0] FLT_STALL = 5'h0d;
	localparam logic [4:0] FLT_OPTION = 5'h0e;
	localparam logic [4:0] FLT_OPTION1 = 5'h0f;
	localparam logic [4:0] FLT_PSTORE = 5'h10;
	localparam logic [4:0] FLT_BRK4 = 5'h11;
	localparam logic [4:0] FLT_BRK5 = 5'h12;
	localparam logic [4:0] FLT_BRK6 = 5'h13;
	localparam logic [4:0] FLT_BRK7 = 5'h14;
	localparam logic [4:0] FLT_INPHASE = 5'h15;
	localparam logic [4:0] FLT_RETRY_EXCESS = 5'h1f;

	// ----------------------------------------------------------------
	// Class masks, bit n set means fault code n may be retried
	// ----------------------------------------------------------------
	localparam logic [31:0] CLS0_MASK = 32'h003f_fffe;
	localparam logic [31:0] CLS1_MASK = 32'h0000_000e;
	localparam logic [31:0] CLS2_MASK = 32'h0000_0070;
	localparam logic [31:0] CLS3_MASK = 32'h0000_007e;
	localparam logic [31:0] CLS4_MASK = 32'h003f_ee7e;
	localparam logic [31:0] CLS5_MASK = 32'h0000_000a;

	// ----------------------------------------------------------------
	// Settings and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] LIMIT_OFF = 8'h00;
	localparam logic [7:0] LIMIT_LOW_MAX = 8'h0a;
	localparam logic [7:0] LIMIT_HIGH_MIN = 8'h65;
	localparam logic [7:0] LIMIT_HIGH_MAX = 8'h6e;
	localparam logic [7:0] LIMIT_HIGH_BASE = 8'h64;
	localparam logic [11:0] WAIT_RESET = 12'h00a;
	localparam logic [11:0] WAIT_MIN = 12'h001;
	localparam logic [11:0] WAIT_MAX = 12'he10;
	localparam logic [15:0] COAST_DISABLED = 16'h270f;
	localparam logic [7:0] TERM_FUNC_POS = 8'h40;
	localparam logic [7:0] TERM_FUNC_NEG = 8'ha4;
	localparam int TICK_MS = 100;
	localparam int CLOCK_MHZ = 100;
	localparam int TICK_CYCLES = TICK_MS * 1000 * CLOCK_MHZ;
	localparam int SUCCESS_FACTOR = 4;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		FRC_IDLE = 4'b0001,
		FRC_WAIT = 4'b0010,
		FRC_RUN = 4'b0100,
		FRC_LOCK = 4'b1000
	} frc_state_e;

	typedef struct packed {
		logic valid;
		logic [4:0] code;
		logic at_power_on;
	} frc_fault_s;

	typedef struct packed {
		logic [2:0] class_sel;
		logic [7:0] limit;
		logic [11:0] wait_ticks;
		logic [15:0] coast_time;
		logic [7:0] term_func;
	} frc_cfg_s;

endpackage : frc_pkg

//--- rtl/frc_fault_retry.sv
/*
 * Fault retry controller: waits after a trip, clears the fault, restarts, counts outcomes.
 * Assumes the trip logic presents one fault per cycle and registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RULE1] Class setting 0-5 selects retriable faults.
// [RULE2] Limit zero disables all retrying.
// [RULE3] Limit 1-10: count, fault output hidden.
// [RULE4] Limit 101-110: count minus 100, output shown.
// [RULE5] Wait, clear fault, restart at start frequency.
// [RULE6] Too many failures raise excess fault.
// [RULE7] Four waits fault-free means success.
// [RULE8] Success count readable, write zero clears.
// [RULE9] Retry-active output, function code 64/164.
// [RULE10] Class table maps to fault sets.
// [RULE11] Record keeps only first fault.
// [RULE12] Retry reset keeps thermal and brake data; the code drives only keep_thermal_data, tied high.
// [RULE13] Power-on storage fault never retried.
// [RULE14] Unselected fault during wait abandons retry.
// [RULE15] Coast time not 9999: power-loss restart.
// [RULE16] Recurring fault before success counts failure.
module frc_fault_retry #(
	parameter int TICK_CYC = frc_pkg::TICK_CYCLES,
	parameter int COUNT_W = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Fault side
	input var frc_pkg::frc_fault_s fault_in,
	input wire logic run_active,
	output logic fault_clear,
	output logic restart_start_freq,
	output logic restart_flying,
	output logic keep_thermal_data,
	output logic fault_output,
	output logic [4:0] fault_record,
	output logic trip_excess,
	// Configuration
	input var frc_pkg::frc_cfg_s cfg,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// Status and interrupt
	output logic retry_active,
	output logic retry_active_output,
	output logic irq
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic retriable(input logic [2:0] sel, input logic [4:0] code);
		logic [31:0] m;
		m = 32'h0;
		case (sel)
			3'h0: m = frc_pkg::CLS0_MASK;
			3'h1: m = frc_pkg::CLS1_MASK;
			3'h2: m = frc_pkg::CLS2_MASK;
			3'h3: m = frc_pkg::CLS3_MASK;
			3'h4: m = frc_pkg::CLS4_MASK;
			3'h5: m = frc_pkg::CLS5_MASK;
			default: m = 32'h0;
		endcase
		return m[code];
	endfunction : retriable

	localparam logic [1:0] ADDR_COUNT = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_MASK = 2'h2;
	localparam logic [1:0] ADDR_STATE = 2'h3;

	frc_pkg::frc_state_e state_q;
	logic [3:0] allowed;
	logic hidden_mode;
	logic [3:0] fail_q;
	logic [31:0] tick_q;
	logic tick;
	logic [13:0] time_q;
	logic [COUNT_W-1:0] success_q;
	logic [2:0] stat_q;
	logic [2:0] mask_q;
	logic first_q;
	logic sel_fault;
	logic wait_done;
	logic run_done;
	logic fail_now;
	logic ev_success;
	logic ev_excess;
	logic ev_fail;

	// ----------------------------------------------------------------
	// Limit and class decode
	// ----------------------------------------------------------------
	// [RULE2] Limit decode.
	// [RULE3] Low range hides output.
	// [RULE4] High range subtracts base.
	always_comb begin
		allowed = 4'h0;
		hidden_mode = 1'b0;
		if (cfg.limit >= 8'h01 && cfg.limit <= frc_pkg::LIMIT_LOW_MAX) begin
			allowed = cfg.limit[3:0];
			hidden_mode = 1'b1;
		end else if (cfg.limit >= frc_pkg::LIMIT_HIGH_MIN && cfg.limit <= frc_pkg::LIMIT_HIGH_MAX) begin
			allowed = 4'((cfg.limit - frc_pkg::LIMIT_HIGH_BASE));
		end
	end

	// [RULE1] Class selection.
	// [RULE10] Class table lookup.
	// [RULE13] Power-on storage fault excluded.
	assign sel_fault = fault_in.valid && retriable(cfg.class_sel, fault_in.code)
		&& !(fault_in.code == frc_pkg::FLT_PSTORE && fault_in.at_power_on);

	// ----------------------------------------------------------------
	// Timebase
	// ----------------------------------------------------------------
	// A 0.1 s tick keeps the wait counter narrow; timing is exact to one tick.
	always_ff @(posedge clock) begin
		if (reset || tick) begin
			tick_q <= 32'h0;
		end else begin
			tick_q <= tick_q + 32'h1;
		end
	end
	assign tick = (tick_q == 32'(TICK_CYC - 1));

	// A failed retry restarts the wait from zero, so a long run never shortens the next wait.
	always_ff @(posedge clock) begin
		if (reset || state_q == frc_pkg::FRC_IDLE || state_q == frc_pkg::FRC_LOCK || fault_clear
			|| ev_fail) begin
			time_q <= 14'h0;
		end else if (tick) begin
			time_q <= time_q + 14'h1;
		end
	end

	// [RULE5] Wait time in ticks.
	assign wait_done = (state_q == frc_pkg::FRC_WAIT) && (time_q >= {2'h0, cfg.wait_ticks});
	// [RULE7] Four waits from start.
	assign run_done = (state_q == frc_pkg::FRC_RUN) && run_active && !fault_in.valid
		&& (time_q > 14'(cfg.wait_ticks * 4));
	// [RULE16] Recurrence before success.
	// The fault just cleared still stands in the clear cycle; it is no recurrence.
	assign fail_now = (state_q == frc_pkg::FRC_RUN) && fault_in.valid && !fault_clear;
	assign ev_fail = fail_now && sel_fault;
	assign ev_success = run_done;
	// [RULE6] Failure count over limit.
	assign ev_excess = ev_fail && (fail_q >= allowed);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= frc_pkg::FRC_IDLE;
		end else begin
			case (state_q)
				frc_pkg::FRC_IDLE: begin
					if (fault_in.valid) begin
						state_q <= (sel_fault && allowed != 4'h0) ? frc_pkg::FRC_WAIT
							: frc_pkg::FRC_LOCK;
					end
				end
				frc_pkg::FRC_WAIT: begin
					// [RULE14] Unselected fault abandons.
					if (fault_in.valid && !sel_fault) begin
						state_q <= frc_pkg::FRC_LOCK;
					end else if (wait_done) begin
						state_q <= frc_pkg::FRC_RUN;
					end
				end
				frc_pkg::FRC_RUN: begin
					if (ev_excess || (fail_now && !sel_fault)) begin
						state_q <= frc_pkg::FRC_LOCK;
					end else if (ev_fail) begin
						state_q <= frc_pkg::FRC_WAIT;
					end else if (ev_success) begin
						state_q <= frc_pkg::FRC_IDLE;
					end
				end
				// Only reset leaves the lock, so a tripped drive never restarts by itself.
				frc_pkg::FRC_LOCK: state_q <= frc_pkg::FRC_LOCK;
				default: state_q <= frc_pkg::FRC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset || ev_success) begin
			fail_q <= 4'h0;
		end else if (ev_fail) begin
			fail_q <= fail_q + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Drive side outputs
	// ----------------------------------------------------------------
	// [RULE5] Clear and restart pulse.
	// [RULE12] Retry reset keeps thermal data.
	// [RULE15] Flying restart when enabled.
	always_ff @(posedge clock) begin
		if (reset) begin
			fault_clear <= 1'b0;
			restart_start_freq <= 1'b0;
			restart_flying <= 1'b0;
		end else begin
			fault_clear <= wait_done && !(fault_in.valid && !sel_fault);
			restart_start_freq <= wait_done && !(fault_in.valid && !sel_fault)
				&& cfg.coast_time == frc_pkg::COAST_DISABLED;
			restart_flying <= wait_done && !(fault_in.valid && !sel_fault)
				&& cfg.coast_time != frc_pkg::COAST_DISABLED;
		end
	end
	// [RULE12] Thermal data kept.
	assign keep_thermal_data = 1'b1;

	// [RULE11] First fault recorded only.
	always_ff @(posedge clock) begin
		if (reset) begin
			fault_record <= 5'h0;
			first_q <= 1'b0;
		end else if (state_q == frc_pkg::FRC_IDLE && fault_in.valid && !first_q) begin
			fault_record <= fault_in.code;
			first_q <= 1'b1;
		end else if (ev_success) begin
			first_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			trip_excess <= 1'b0;
		end else if (ev_excess) begin
			trip_excess <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	// [RULE3] Output hidden while retrying.
	// [RULE4] Output shown while retrying.
	always_ff @(posedge clock) begin
		if (reset) begin
			fault_output <= 1'b0;
		end else begin
			fault_output <= (state_q == frc_pkg::FRC_LOCK) || ev_excess
				|| ((state_q != frc_pkg::FRC_IDLE) && !hidden_mode)
				|| (state_q == frc_pkg::FRC_IDLE && fault_in.valid && !(sel_fault && allowed != 4'h0));
		end
	end

	// [RULE9] Retry active and terminal.
	always_ff @(posedge clock) begin
		if (reset) begin
			retry_active <= 1'b0;
			retry_active_output <= 1'b0;
		end else begin
			retry_active <= (state_q == frc_pkg::FRC_WAIT) || (state_q == frc_pkg::FRC_RUN);
			if (cfg.term_func == frc_pkg::TERM_FUNC_POS) begin
				retry_active_output <= (state_q == frc_pkg::FRC_WAIT) || (state_q == frc_pkg::FRC_RUN);
			end else if (cfg.term_func == frc_pkg::TERM_FUNC_NEG) begin
				retry_active_output <= !((state_q == frc_pkg::FRC_WAIT) || (state_q == frc_pkg::FRC_RUN));
			end else begin
				retry_active_output <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// [RULE8] Success counter, write zero clears.
	always_ff @(posedge clock) begin
		if (reset) begin
			success_q <= '0;
		end else if (ev_success) begin
			success_q <= success_q + COUNT_W'(1);
		end else if (reg_write && reg_addr == ADDR_COUNT && reg_wdata == 16'h0) begin
			success_q <= '0;
		end
	end

	// Set wins over the write-one clear so no event is lost.
	always_ff @(posedge clock) begin
		if (reset) begin
			stat_q <= 3'h0;
		end else begin
			stat_q <= (stat_q & ~((reg_write && reg_addr == ADDR_STATUS) ? reg_wdata[2:0] : 3'h0))
				| {ev_excess, ev_fail, ev_success};
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			mask_q <= 3'h0;
		end else if (reg_write && reg_addr == ADDR_MASK) begin
			mask_q <= reg_wdata[2:0];
		end
	end
	assign irq = |(stat_q & mask_q);

	always_ff @(posedge clock) begin
		if (reset) begin
			reg_rdata <= 16'h0;
		end else if (reg_read) begin
			case (reg_addr)
				ADDR_COUNT: reg_rdata <= 16'(success_q);
				ADDR_STATUS: reg_rdata <= {13'h0, stat_q};
				ADDR_MASK: reg_rdata <= {13'h0, mask_q};
				ADDR_STATE: reg_rdata <= {8'h0, fail_q, state_q};
				default: reg_rdata <= 16'h0;
			endcase
		end else begin
			reg_rdata <= 16'h0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_limit_off: assert property (@(posedge clock) disable iff (reset) // [RULE2]
		cfg.limit == frc_pkg::LIMIT_OFF && state_q == frc_pkg::FRC_IDLE |=> state_q != frc_pkg::FRC_WAIT)
		else $error("retry started with limit zero");
	a_hidden_out: assert property (@(posedge clock) disable iff (reset) // [RULE3]
		hidden_mode && state_q == frc_pkg::FRC_WAIT && $past(state_q) == frc_pkg::FRC_WAIT
		|-> !fault_output) else $error("fault output shown in hidden mode");
	a_shown_out: assert property (@(posedge clock) disable iff (reset) // [RULE4]
		!hidden_mode && $stable(cfg) && state_q == frc_pkg::FRC_WAIT |=> fault_output)
		else $error("fault output not shown");
	a_clear_pulse: assert property (@(posedge clock) disable iff (reset) // [RULE5]
		wait_done && !(fault_in.valid && !sel_fault) |=> fault_clear ##1 !fault_clear)
		else $error("clear pulse wrong");
	a_excess_trip: assert property (@(posedge clock) disable iff (reset) // [RULE6]
		ev_excess |=> trip_excess && state_q == frc_pkg::FRC_LOCK) else $error("excess not tripped");
	a_success_inc: assert property (@(posedge clock) disable iff (reset) // [RULE7]
		ev_success |=> success_q == $past(success_q) + COUNT_W'(1) && fail_q == 4'h0)
		else $error("success not counted");
	a_count_clear: assert property (@(posedge clock) disable iff (reset) // [RULE8]
		reg_write && reg_addr == ADDR_COUNT && reg_wdata == 16'h0 && !ev_success |=> success_q == '0)
		else $error("count not cleared");
	a_active_flag: assert property (@(posedge clock) disable iff (reset) // [RULE9]
		state_q == frc_pkg::FRC_RUN |=> retry_active) else $error("retry active missing");
	a_pstore_skip: assert property (@(posedge clock) disable iff (reset) // [RULE13]
		state_q == frc_pkg::FRC_IDLE && fault_in.valid && fault_in.at_power_on
		&& fault_in.code == frc_pkg::FLT_PSTORE |=> state_q == frc_pkg::FRC_LOCK)
		else $error("power-on storage fault retried");
	a_abandon_wait: assert property (@(posedge clock) disable iff (reset) // [RULE14]
		state_q == frc_pkg::FRC_WAIT && fault_in.valid && !sel_fault |=> state_q == frc_pkg::FRC_LOCK)
		else $error("unselected fault did not abandon");
	a_first_rec: assert property (@(posedge clock) disable iff (reset) // [RULE11]
		first_q && !ev_success |=> $stable(fault_record)) else $error("record overwritten");
	a_fail_count: assert property (@(posedge clock) disable iff (reset) // [RULE16]
		ev_fail && !ev_excess |=> fail_q == $past(fail_q) + 4'h1 && state_q == frc_pkg::FRC_WAIT)
		else $error("retry failure not counted");
	a_wait_fresh: assert property (@(posedge clock) disable iff (reset) // [RULE5]
		ev_fail |=> time_q == 14'h0) else $error("wait not restarted after failure");
	a_restart_kind: assert property (@(posedge clock) disable iff (reset) // [RULE15]
		fault_clear |-> restart_flying == ($past(cfg.coast_time) != frc_pkg::COAST_DISABLED))
		else $error("restart kind wrong");

	c_success: cover property (@(posedge clock) ev_success);
	c_excess: cover property (@(posedge clock) ev_excess);
	c_abandon: cover property (@(posedge clock) state_q == frc_pkg::FRC_WAIT && fault_in.valid && !sel_fault);
	c_fail_retry: cover property (@(posedge clock) ev_fail && !ev_excess);
	c_flying: cover property (@(posedge clock) restart_flying);

endmodule : frc_fault_retry

`default_nettype wire

//--- verification/frc_trip_model.sv
/*
 * Trip logic model: reports a fault until the controller clears it, then runs fault-free.
 * Assumes it shares one clock and one synchronous reset with the controller.
 */
`timescale 1ns/1ps
`default_nettype none
module frc_trip_model (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Bench commands
	input wire logic inject,
	input wire logic [4:0] inj_code,
	input wire logic inj_pon,
	// Controller side
	input wire logic fault_clear,
	output var frc_pkg::frc_fault_s fault_in,
	output logic run_active
);
	always_ff @(posedge clock) begin
		if (reset) begin
			fault_in <= '0;
			run_active <= 1'b0;
		end else if (inject) begin
			fault_in <= '{valid: 1'b1, code: inj_code, at_power_on: inj_pon};
			run_active <= 1'b0;
		end else if (fault_clear) begin
			// A released code line shows junk so a stale code is never mistaken for a fault.
			fault_in <= '{valid: 1'b0, code: ~fault_in.code, at_power_on: 1'b0};
			run_active <= 1'b1;
		end
	end
endmodule : frc_trip_model
`default_nettype wire

//--- verification/tb_fault_retry_controller.sv
/*
 * Self-checking bench for the fault retry controller, one task per scenario.
 * Assumes the trip logic model on the fault side and a tick of ten clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_fault_retry_controller;
	logic clock, reset, inject, inj_pon, run_active, fault_clear, restart_start_freq;
	logic restart_flying, keep_thermal_data, fault_output, trip_excess, reg_write, reg_read;
	logic retry_active, retry_active_output, irq, seen;
	logic [4:0] inj_code, fault_record;
	logic [1:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd;
	logic [3:0] obs;
	frc_pkg::frc_fault_s fault_in;
	frc_pkg::frc_cfg_s cfg;
	int fail_count, checks_done, cycles;
	assign obs = {~retry_active, trip_excess, fault_clear, retry_active};

	frc_fault_retry #(.TICK_CYC(10)) frc_fault_retry_inst (.clock, .reset, .fault_in,
		.run_active, .fault_clear, .restart_start_freq, .restart_flying,
		.keep_thermal_data, .fault_output, .fault_record, .trip_excess, .cfg,
		.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .retry_active,
		.retry_active_output, .irq);
	frc_trip_model frc_trip_model_inst (.clock, .reset, .inject, .inj_code, .inj_pon,
		.fault_clear, .fault_in, .run_active);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s: got %h want %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	task automatic setup(input logic [2:0] c, input logic [7:0] l, input logic [15:0] co,
		input logic [7:0] t);
		@(posedge clock);
		cfg <= '{class_sel: c, limit: l, wait_ticks: 12'h002, coast_time: co, term_func: t};
		reset <= 1'b1;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		#1;
	endtask : setup

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [1:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdr

	task automatic inj(input logic [4:0] c, input logic p);
		@(posedge clock);
		inject <= 1'b1;
		inj_code <= c;
		inj_pon <= p;
		@(posedge clock);
		inject <= 1'b0;
	endtask : inj

	// Waits a bounded number of cycles for one watched bit of obs to go high.
	task automatic wait_bit(input int i, input int n);
		seen = 1'b0;
		repeat (n) begin
			@(posedge clock);
			#1;
			if (obs[i] === 1'b1) begin
				seen = 1'b1;
				break;
			end
		end
	endtask : wait_bit

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		setup(3'h0, 8'h00, frc_pkg::COAST_DISABLED, frc_pkg::TERM_FUNC_POS);
		chk(keep_thermal_data, 1'b1, "thermal data kept");
		chk({trip_excess, fault_output, retry_active}, 3'h0, "idle outputs");
		rdr(2'h0);
		chk(rd, 16'h0000, "count after reset");
		$display("t_reset done");
	endtask : t_reset

	task automatic t_class();
		logic [2:0] cs [11] = '{3'h5, 3'h5, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h0, 3'h3, 3'h0,
			3'h0};
		logic [4:0] cd [11] = '{frc_pkg::FLT_OC2, frc_pkg::FLT_OC3, frc_pkg::FLT_OV1,
			frc_pkg::FLT_OV2, frc_pkg::FLT_OC1, frc_pkg::FLT_MTHERM, frc_pkg::FLT_BRAKE,
			frc_pkg::FLT_ETHERM, frc_pkg::FLT_MTHERM, frc_pkg::FLT_PSTORE, frc_pkg::FLT_OC1};
		logic [10:0] ex = 11'h0da;
		for (int i = 0; i < 11; i++) begin
			setup(cs[i], (i == 10) ? 8'h00 : 8'h03, frc_pkg::COAST_DISABLED, 8'h00);
			inj(cd[i], i == 9);
			wait_bit(0, 6);
			chk(seen, ex[i], "class selection");
		end
		$display("t_class done");
	endtask : t_class

	task automatic t_success();
		setup(3'h1, 8'h03, frc_pkg::COAST_DISABLED, frc_pkg::TERM_FUNC_POS);
		wr(2'h2, 16'h0001);
		inj(frc_pkg::FLT_OC2, 1'b0);
		wait_bit(0, 6);
		chk(retry_active_output, 1'b1, "terminal positive");
		chk(fault_output, 1'b0, "fault output hidden");
		wait_bit(1, 60);
		chk(seen, 1'b1, "fault cleared");
		chk({restart_start_freq, restart_flying}, 2'b10, "start frequency restart");
		wait_bit(3, 75);
		chk(seen, 1'b0, "success too early");
		wait_bit(3, 50);
		chk(seen, 1'b1, "success");
		rdr(2'h0);
		chk(rd, 16'h0001, "success count");
		chk(irq, 1'b1, "irq raised");
		wr(2'h2, 16'h0000);
		#1 chk(irq, 1'b0, "irq masked");
		wr(2'h2, 16'h0001);
		wr(2'h1, 16'h0001);
		#1 chk(irq, 1'b0, "irq cleared");
		wr(2'h0, 16'h0005);
		rdr(2'h0);
		chk(rd, 16'h0001, "nonzero write ignored");
		wr(2'h0, 16'h0000);
		rdr(2'h0);
		chk(rd, 16'h0000, "count cleared");
		$display("t_success done");
	endtask : t_success

	task automatic t_excess();
		setup(3'h1, 8'h65, 16'h0000, frc_pkg::TERM_FUNC_POS);
		inj(frc_pkg::FLT_OC1, 1'b0);
		wait_bit(0, 6);
		chk(fault_output, 1'b1, "fault output shown");
		wait_bit(1, 60);
		chk({seen, restart_start_freq, restart_flying}, 3'b101, "power loss restart");
		repeat (30) @(posedge clock);
		inj(frc_pkg::FLT_OC3, 1'b0);
		wait_bit(1, 10);
		chk(seen, 1'b0, "second wait cut short");
		wait_bit(1, 60);
		chk(seen, 1'b1, "second retry");
		rdr(2'h3);
		chk(rd[7:4], 4'h1, "failure count");
		inj(frc_pkg::FLT_OC3, 1'b0);
		wait_bit(2, 8);
		chk(seen, 1'b1, "excess fault");
		@(posedge clock);
		#1 chk(retry_active, 1'b0, "retry stopped");
		chk(fault_output, 1'b1, "excess fault shown");
		chk(fault_record, frc_pkg::FLT_OC1, "first fault kept");
		wait_bit(1, 60);
		chk(seen, 1'b0, "no retry after excess");
		$display("t_excess done");
	endtask : t_excess

	task automatic t_abandon();
		setup(3'h1, 8'h03, frc_pkg::COAST_DISABLED, frc_pkg::TERM_FUNC_NEG);
		inj(frc_pkg::FLT_OC1, 1'b0);
		wait_bit(0, 6);
		chk(retry_active_output, 1'b0, "terminal negative");
		inj(frc_pkg::FLT_OV1, 1'b0);
		wait_bit(1, 60);
		chk(seen, 1'b0, "retry abandoned");
		chk(fault_output, 1'b1, "fault still shown");
		chk(retry_active_output, 1'b1, "negative terminal idle");
		$display("t_abandon done");
	endtask : t_abandon

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			conclude();
		end
	end

	initial begin
		reset = 1'b1;
		inject = 1'b0;
		inj_code = 5'h00;
		inj_pon = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		cfg = '0;
		fail_count = 0;
		checks_done = 0;
		cycles = 0;
		t_reset();
		t_class();
		t_success();
		t_excess();
		t_abandon();
		conclude();
	end
endmodule : tb_fault_retry_controller
`default_nettype wire
